// [core/lpft_pkg.sv]
// shared constants and types for the learnt program and file transfer block
package lpft_pkg;
    localparam int CLK_KHZ = 200000;
    localparam int CHAR_TIME_MS = 1;
    localparam int CHAR_CYCLES = CHAR_TIME_MS * CLK_KHZ;
    localparam int PROG_SLOTS = 9;
    localparam logic [3:0] PROG_NUM_MIN = 4'h1;
    localparam logic [3:0] PROG_NUM_MAX = 4'h9;
    localparam int PROG_BYTES = 256;
    localparam int MEM_DEPTH = PROG_SLOTS * PROG_BYTES;
    localparam int MEM_AW = 12;
    localparam logic [7:0] PROG_MAX_LEN = 8'hff;
    localparam logic [7:0] CH_DC1 = 8'h11;
    localparam logic [7:0] CH_DC2 = 8'h12;
    localparam logic [7:0] CH_DC3 = 8'h13;
    localparam logic [7:0] CH_DC4 = 8'h14;
    localparam logic [7:0] CH_LF = 8'h0a;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_QUIT = 8'h51;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [17:0] RST_PACE = 18'h0_0000;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_LIST = 4'h1,
        OP_LEARN = 4'h2,
        OP_EXEC = 4'h3,
        OP_QUERY = 4'h4,
        OP_EDIT = 4'h5,
        OP_NEXT = 4'h6,
        OP_QUIT = 4'h7,
        OP_FILE_OUT = 4'h8,
        OP_CLEAR_FILE = 4'h9
    } lpft_op_type;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_LEARN_DC = 4'h1,
        ST_LEARN = 4'h2,
        ST_LIST_DC = 4'h3,
        ST_RD = 4'h4,
        ST_LOAD = 4'h5,
        ST_TX = 4'h6,
        ST_END3 = 4'h7,
        ST_END4 = 4'h8,
        ST_EDIT = 4'h9,
        ST_FILE = 4'ha,
        ST_FTX = 4'hb
    } lpft_state_type;
endpackage : lpft_pkg

// [core/lpft_mem_if.sv]
// carrier between the interpreter and its program store
`timescale 1ns/10ps
interface lpft_mem_if;
    import lpft_pkg::*;
    logic wr_en;
    logic [MEM_AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface : lpft_mem_if

// [core/lpft_prog_mem.sv]
// program text store, registered read
`timescale 1ns/10ps
module lpft_prog_mem (
    input wire logic i_clk,
    lpft_mem_if.mem mif
);
    import lpft_pkg::*;
    logic [7:0] mem_ff [MEM_DEPTH];
    logic [7:0] rdata_ff;

    always_ff @(posedge i_clk) begin
        if (mif.wr_en) begin
            mem_ff[mif.addr] <= mif.wdata;
        end
        rdata_ff <= mem_ff[mif.addr];
    end

    assign mif.rdata = rdata_ff;
endmodule : lpft_prog_mem

// [core/lpft_core.sv]
// learnt program transfer and file output command interpreter
`timescale 1ns/10ps
module lpft_core #(
    parameter int CHAR_CYC = lpft_pkg::CHAR_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cmd_valid,
    input wire lpft_pkg::lpft_op_type i_cmd_op,
    input wire logic [3:0] i_cmd_num,
    input wire logic i_cmd_serial,
    output logic o_cmd_ready,
    input wire logic i_local_mode,
    input wire logic i_halted,
    input wire logic i_meas_busy,
    input wire logic [7:0] i_term_char,
    input wire logic i_dump_format,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_rx_ready,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_serial,
    output logic o_tx_over_limit,
    input wire logic i_tx_ready,
    input wire logic i_file_valid,
    input wire logic [7:0] i_file_data,
    input wire logic i_file_last,
    output logic o_file_ready,
    input wire logic i_limit_en,
    input wire logic [7:0] i_limit_hi,
    output logic o_clear_file,
    input wire logic i_panel_exec,
    input wire logic [3:0] i_panel_num,
    output logic o_exec_valid,
    output logic [3:0] o_exec_num,
    output logic o_edit_mode,
    output logic o_count_valid,
    output logic [7:0] o_count
);
    import lpft_pkg::*;

    localparam logic [17:0] PACE_LOAD = 18'(CHAR_CYC - 1);

    lpft_mem_if mif ();

    lpft_prog_mem u_mem (
        .i_clk(i_clk),
        .mif(mif)
    );

    lpft_state_type state_ff, nxt_state;
    logic [3:0] slot_ff, nxt_slot;
    logic [7:0] ptr_ff, nxt_ptr;
    logic serial_ff, nxt_serial;
    logic edit_ff, nxt_edit;
    logic eol_ff, nxt_eol;
    logic last_ff, nxt_last;
    logic lstart_ff, nxt_lstart;
    logic quit_ff, nxt_quit;
    logic [17:0] pace_ff, nxt_pace;
    logic [7:0] tx_ff, nxt_tx;
    logic over_ff, nxt_over;
    logic [7:0] len_ff [PROG_SLOTS];
    logic [7:0] nxt_len [PROG_SLOTS];
    logic [7:0] lines_ff [PROG_SLOTS];
    logic [7:0] nxt_lines [PROG_SLOTS];
    logic pend_ff, nxt_pend;
    logic [3:0] pnum_ff, nxt_pnum;
    logic exec_ff, nxt_exec;
    logic [3:0] enum_ff, nxt_enum;
    logic cnt_v_ff, nxt_cnt_v;
    logic [7:0] cnt_ff, nxt_cnt;
    logic clr_ff, nxt_clr;

    logic num_ok;
    logic [3:0] cmd_slot;
    logic take;
    logic tx_go;

    // numbers outside one to nine are dropped silently
    assign num_ok = (i_cmd_num >= PROG_NUM_MIN) && (i_cmd_num <= PROG_NUM_MAX);
    assign cmd_slot = 4'(i_cmd_num - PROG_NUM_MIN);
    assign o_cmd_ready = (state_ff == ST_IDLE) || (state_ff == ST_EDIT);
    assign take = i_cmd_valid && o_cmd_ready;
    assign o_rx_ready = (state_ff == ST_LEARN);
    assign o_file_ready = (state_ff == ST_FILE);
    // pacing gate only holds back bytes of a bus listing outside edit mode
    assign tx_go = (state_ff == ST_TX) && (pace_ff == RST_PACE);
    assign o_tx_valid = tx_go || (state_ff == ST_LEARN_DC) || (state_ff == ST_LIST_DC) ||
                        (state_ff == ST_END3) || (state_ff == ST_END4) || (state_ff == ST_FTX);
    assign o_tx_data = tx_ff;
    assign o_tx_serial = serial_ff;
    assign o_tx_over_limit = over_ff;
    assign o_exec_valid = exec_ff;
    assign o_exec_num = enum_ff;
    assign o_edit_mode = edit_ff;
    assign o_count_valid = cnt_v_ff;
    assign o_count = cnt_ff;
    assign o_clear_file = clr_ff;

    // program store port: learn writes, every other state reads at the pointer
    assign mif.addr = {slot_ff, ptr_ff};
    assign mif.wdata = i_rx_data;
    // the learn path writes only the program store; no port can reach the file
    assign mif.wr_en = (state_ff == ST_LEARN) && i_rx_valid && (i_rx_data != CH_DC3) &&
                       (ptr_ff != PROG_MAX_LEN);

    always_comb begin
        nxt_state = state_ff;
        nxt_slot = slot_ff;
        nxt_ptr = ptr_ff;
        nxt_serial = serial_ff;
        nxt_edit = edit_ff;
        nxt_eol = eol_ff;
        nxt_last = last_ff;
        nxt_lstart = lstart_ff;
        nxt_quit = quit_ff;
        nxt_pace = (pace_ff != RST_PACE) ? 18'(pace_ff - 18'h0_0001) : pace_ff;
        nxt_tx = tx_ff;
        nxt_over = over_ff;
        nxt_len = len_ff;
        nxt_lines = lines_ff;
        nxt_pend = pend_ff;
        nxt_pnum = pnum_ff;
        nxt_exec = 1'b0;
        nxt_enum = enum_ff;
        nxt_cnt_v = 1'b0;
        nxt_cnt = cnt_ff;
        nxt_clr = 1'b0;

        // execute is parked while a measurement runs
        if (pend_ff && !i_meas_busy) begin
            nxt_pend = 1'b0;
            nxt_exec = 1'b1;
            nxt_enum = pnum_ff;
        end else if (i_panel_exec && !pend_ff && (i_panel_num >= PROG_NUM_MIN) &&
                     (i_panel_num <= PROG_NUM_MAX)) begin
            nxt_pend = 1'b1;
            nxt_pnum = i_panel_num;
        end

        case (state_ff)
            ST_IDLE: begin
                if (take) begin
                    nxt_serial = i_cmd_serial;
                    nxt_slot = cmd_slot;
                    nxt_ptr = RST_BYTE;
                    nxt_over = 1'b0;
                    case (i_cmd_op)
                        OP_LIST: begin
                            if (num_ok && (len_ff[cmd_slot] != RST_BYTE) &&
                                (!i_cmd_serial || i_local_mode)) begin
                                nxt_edit = 1'b0;
                                nxt_tx = CH_DC2;
                                nxt_state = i_cmd_serial ? ST_LIST_DC : ST_RD;
                            end
                        end
                        OP_LEARN: begin
                            if (num_ok && (!i_cmd_serial || i_local_mode)) begin
                                nxt_len[cmd_slot] = RST_BYTE;
                                nxt_lines[cmd_slot] = RST_BYTE;
                                nxt_lstart = 1'b1;
                                nxt_quit = 1'b0;
                                nxt_tx = CH_DC1;
                                nxt_state = i_cmd_serial ? ST_LEARN_DC : ST_LEARN;
                            end
                        end
                        OP_EXEC: begin
                            if (num_ok && (len_ff[cmd_slot] != RST_BYTE)) begin
                                nxt_pend = 1'b1;
                                nxt_pnum = i_cmd_num;
                            end
                        end
                        OP_QUERY: begin
                            if (num_ok) begin
                                nxt_cnt_v = 1'b1;
                                nxt_cnt = lines_ff[cmd_slot];
                            end
                        end
                        OP_EDIT: begin
                            if (num_ok && (len_ff[cmd_slot] != RST_BYTE)) begin
                                nxt_edit = 1'b1;
                                nxt_state = ST_RD;
                            end
                        end
                        OP_FILE_OUT: begin
                            if (i_halted) begin
                                nxt_state = ST_FILE;
                            end
                        end
                        OP_CLEAR_FILE: begin
                            nxt_clr = 1'b1;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_LEARN_DC: begin
                if (i_tx_ready) begin
                    nxt_state = ST_LEARN;
                end
            end
            ST_LEARN: begin
                // replayed DC3 ends nothing; the quit line does
                if (i_rx_valid && (i_rx_data != CH_DC3)) begin
                    if (ptr_ff != PROG_MAX_LEN) begin
                        nxt_ptr = 8'(ptr_ff + 8'h01);
                        nxt_len[slot_ff] = 8'(ptr_ff + 8'h01);
                    end
                    nxt_lstart = 1'b0;
                    if (i_rx_data == CH_LF) begin
                        nxt_lines[slot_ff] = 8'(lines_ff[slot_ff] + 8'h01);
                        nxt_lstart = 1'b1;
                        nxt_quit = 1'b0;
                        if (quit_ff) begin
                            nxt_state = ST_IDLE;
                        end
                    end else if (i_rx_data == CH_STAR) begin
                        nxt_lstart = lstart_ff;
                    end else begin
                        nxt_quit = lstart_ff && (i_rx_data == CH_QUIT);
                    end
                end
            end
            ST_LIST_DC: begin
                if (i_tx_ready) begin
                    nxt_state = ST_RD;
                end
            end
            ST_RD: begin
                nxt_state = ST_LOAD;
            end
            ST_LOAD: begin
                nxt_eol = (mif.rdata == CH_LF);
                nxt_last = (8'(ptr_ff + 8'h01) == len_ff[slot_ff]);
                // on the bus a stored line end goes out as the chosen terminator
                nxt_tx = (!serial_ff && (mif.rdata == CH_LF)) ? i_term_char : mif.rdata;
                nxt_state = ST_TX;
            end
            ST_TX: begin
                if (tx_go && i_tx_ready) begin
                    nxt_ptr = 8'(ptr_ff + 8'h01);
                    if (!serial_ff && !edit_ff) begin
                        nxt_pace = PACE_LOAD;
                    end
                    if (edit_ff && (eol_ff || last_ff)) begin
                        nxt_state = ST_EDIT;
                    end else if (last_ff) begin
                        nxt_tx = CH_DC3;
                        nxt_state = serial_ff ? ST_END3 : ST_IDLE;
                    end else begin
                        nxt_state = ST_RD;
                    end
                end
            end
            ST_END3: begin
                if (i_tx_ready) begin
                    nxt_tx = CH_DC4;
                    nxt_state = ST_END4;
                end
            end
            ST_END4: begin
                if (i_tx_ready) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_EDIT: begin
                // the line stays unsent until the controller asks for it
                if (take && (i_cmd_op == OP_NEXT) && (ptr_ff != len_ff[slot_ff])) begin
                    nxt_state = ST_RD;
                end else if (take && (i_cmd_op == OP_QUIT)) begin
                    nxt_edit = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            ST_FILE: begin
                if (i_file_valid) begin
                    // dump format is raw, other formats take the terminator on the bus
                    nxt_tx = (!serial_ff && !i_dump_format && (i_file_data == CH_LF)) ?
                             i_term_char : i_file_data;
                    nxt_over = i_limit_en && (i_file_data > i_limit_hi);
                    nxt_last = i_file_last;
                    nxt_state = ST_FTX;
                end
            end
            ST_FTX: begin
                if (i_tx_ready) begin
                    nxt_state = last_ff ? ST_IDLE : ST_FILE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_ff <= ST_IDLE;
            slot_ff <= 4'h0;
            ptr_ff <= RST_BYTE;
            serial_ff <= 1'b0;
            edit_ff <= 1'b0;
            eol_ff <= 1'b0;
            last_ff <= 1'b0;
            lstart_ff <= 1'b1;
            quit_ff <= 1'b0;
            pace_ff <= RST_PACE;
            tx_ff <= RST_BYTE;
            over_ff <= 1'b0;
            for (int i = 0; i < PROG_SLOTS; i++) begin
                len_ff[i] <= RST_BYTE;
                lines_ff[i] <= RST_BYTE;
            end
            pend_ff <= 1'b0;
            pnum_ff <= 4'h0;
            exec_ff <= 1'b0;
            enum_ff <= 4'h0;
            cnt_v_ff <= 1'b0;
            cnt_ff <= RST_BYTE;
            clr_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            slot_ff <= nxt_slot;
            ptr_ff <= nxt_ptr;
            serial_ff <= nxt_serial;
            edit_ff <= nxt_edit;
            eol_ff <= nxt_eol;
            last_ff <= nxt_last;
            lstart_ff <= nxt_lstart;
            quit_ff <= nxt_quit;
            pace_ff <= nxt_pace;
            tx_ff <= nxt_tx;
            over_ff <= nxt_over;
            len_ff <= nxt_len;
            lines_ff <= nxt_lines;
            pend_ff <= nxt_pend;
            pnum_ff <= nxt_pnum;
            exec_ff <= nxt_exec;
            enum_ff <= nxt_enum;
            cnt_v_ff <= nxt_cnt_v;
            cnt_ff <= nxt_cnt;
            clr_ff <= nxt_clr;
        end
    end
endmodule : lpft_core

// [sim/lpft_sink_model.sv]
// far-side device model that takes bytes from the interpreter
`timescale 1ns/10ps
module lpft_sink_model (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_slow,
    output logic o_tx_ready
);
    logic [1:0] cnt_ff;
    logic [1:0] nxt_cnt;

    // slow mode opens one cycle in three, so every byte must be held
    always_comb begin
        nxt_cnt = (i_srst || cnt_ff == 2'h2) ? 2'h0 : cnt_ff + 2'h1;
    end

    always_ff @(posedge i_clk) begin
        cnt_ff <= nxt_cnt;
    end

    assign o_tx_ready = !i_slow || cnt_ff == 2'h2;
endmodule : lpft_sink_model

// [sim/lpft_core_asserts.sv]
// concurrent checks on the interpreter top ports
`timescale 1ns/10ps
module lpft_core_asserts
    import lpft_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cmd_valid,
    input wire lpft_pkg::lpft_op_type i_cmd_op,
    input wire logic [3:0] i_cmd_num,
    input wire logic i_cmd_serial,
    input wire logic o_cmd_ready,
    input wire logic i_local_mode,
    input wire logic i_halted,
    input wire logic i_meas_busy,
    input wire logic i_tx_ready,
    input wire logic o_rx_ready,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic o_file_ready,
    input wire logic o_clear_file,
    input wire logic o_exec_valid,
    input wire logic [3:0] o_exec_num,
    input wire logic o_edit_mode,
    input wire logic o_count_valid
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_srst);

    sequence s_take(lpft_op_type op);
        i_cmd_valid && o_cmd_ready && !o_edit_mode && i_cmd_op == op
            && i_cmd_num >= PROG_NUM_MIN && i_cmd_num <= PROG_NUM_MAX;
    endsequence

    sequence s_dc1;
        o_tx_valid && o_tx_data == CH_DC1;
    endsequence

    a_reset_idle: assert property ($fell(i_srst) |-> o_cmd_ready && !o_tx_valid && !o_edit_mode)
        else $error("interpreter not idle after reset");
    a_query_answer: assert property (s_take(OP_QUERY) |=> o_count_valid)
        else $error("line count answer missing");
    a_clear_pulse: assert property (s_take(OP_CLEAR_FILE) |=> o_clear_file)
        else $error("clear file pulse missing");
    a_exec_waits: assert property (o_exec_valid |-> !$past(i_meas_busy))
        else $error("program run during measurement");
    a_exec_range: assert property (o_exec_valid |-> o_exec_num inside {[1:9]})
        else $error("program number out of range");
    a_rx_only_learn: assert property (o_rx_ready |-> !o_cmd_ready && !o_file_ready)
        else $error("port bytes accepted outside learning");
    a_file_halted: assert property ($rose(o_file_ready) |-> $past(i_halted))
        else $error("file read while analysis running");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("byte dropped before sink took it");
    a_quit_leaves: assert property (o_edit_mode && i_cmd_valid && o_cmd_ready
        && i_cmd_op == OP_QUIT |=> !o_edit_mode)
        else $error("edit mode kept after quit");
    a_load_dc1: assert property (s_take(OP_LEARN) ##0 (i_cmd_serial && i_local_mode) |=> s_dc1)
        else $error("serial load without replay start");
endmodule : lpft_core_asserts

bind lpft_core lpft_core_asserts lpft_core_asserts_inst (
    .i_clk, .i_srst, .i_cmd_valid, .i_cmd_op, .i_cmd_num, .i_cmd_serial, .o_cmd_ready,
    .i_local_mode, .i_halted, .i_meas_busy, .i_tx_ready, .o_rx_ready, .o_tx_valid,
    .o_tx_data, .o_file_ready, .o_clear_file, .o_exec_valid, .o_exec_num, .o_edit_mode,
    .o_count_valid
);

// [sim/learnt_program_file_transfer_tb.sv]
// self-checking bench for the learnt program transfer interpreter
`timescale 1ns/10ps
module learnt_program_file_transfer_tb;
    import lpft_pkg::*;
    // fl holds serial, local mode, slow sink, expected edit mode
    typedef struct {
        lpft_op_type op;
        logic [3:0] num;
        logic [3:0] fl;
        logic [7:0] cnt;
        string exp;
    } lpft_row_type;
    logic i_clk, i_srst, i_cmd_valid, i_cmd_serial, i_local_mode, i_halted, i_meas_busy;
    logic i_dump_format, i_rx_valid, i_tx_ready, i_file_valid, i_file_last, i_limit_en;
    logic i_panel_exec, slow, o_cmd_ready, o_rx_ready, o_tx_valid, o_tx_serial;
    logic o_tx_over_limit, o_file_ready, o_clear_file, o_exec_valid, o_edit_mode, o_count_valid;
    lpft_op_type i_cmd_op;
    logic [3:0] i_cmd_num, i_panel_num, o_exec_num, last_num;
    logic [7:0] i_term_char, i_rx_data, i_file_data, i_limit_hi, o_tx_data, o_count;
    logic [7:0] got[$];
    logic over[$];
    int stamp[$];
    int cyc = 0, nexec = 0, nclr = 0, mismatches = 0, num_checks = 0;
    string fexp[3] = '{"A\n\220", "A\n\220", "A.\220"};
    lpft_row_type rows[13] = '{
        '{OP_QUERY, 4'h3, 4'h0, 8'h03, ""},
        '{OP_QUERY, 4'h7, 4'h0, 8'h00, ""},
        '{OP_LIST, 4'h3, 4'h0, 8'h00, "B.CD.Q."},
        '{OP_LIST, 4'h2, 4'he, 8'h00, "\022B\nCD\nQ\n\023\024"},
        '{OP_LIST, 4'h2, 4'h8, 8'h00, ""},
        '{OP_LIST, 4'h5, 4'h0, 8'h00, ""},
        '{OP_LIST, 4'h0, 4'h0, 8'h00, ""},
        '{OP_EDIT, 4'h3, 4'h3, 8'h00, "B."},
        '{OP_NEXT, 4'h3, 4'h3, 8'h00, "CD."},
        '{OP_LIST, 4'h3, 4'h3, 8'h00, ""},
        '{OP_NEXT, 4'h3, 4'h3, 8'h00, "Q."},
        '{OP_NEXT, 4'h3, 4'h3, 8'h00, ""},
        '{OP_QUIT, 4'h3, 4'h2, 8'h00, ""}
    };

    lpft_core #(.CHAR_CYC(8)) lpft_core_inst (
        .i_clk, .i_srst, .i_cmd_valid, .i_cmd_op, .i_cmd_num, .i_cmd_serial, .o_cmd_ready,
        .i_local_mode, .i_halted, .i_meas_busy, .i_term_char, .i_dump_format, .i_rx_valid,
        .i_rx_data, .o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_serial, .o_tx_over_limit,
        .i_tx_ready, .i_file_valid, .i_file_data, .i_file_last, .o_file_ready, .i_limit_en,
        .i_limit_hi, .o_clear_file, .i_panel_exec, .i_panel_num, .o_exec_valid, .o_exec_num,
        .o_edit_mode, .o_count_valid, .o_count
    );
    lpft_sink_model lpft_sink_model_inst (.i_clk, .i_srst, .i_slow(slow), .o_tx_ready(i_tx_ready));

    initial begin
        i_clk = 1'h0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        nclr <= nclr + o_clear_file;
        if (o_tx_valid && i_tx_ready) begin
            got.push_back(o_tx_data);
            over.push_back(o_tx_over_limit);
            stamp.push_back(cyc);
        end
        if (o_exec_valid) begin
            nexec <= nexec + 1;
            last_num <= o_exec_num;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic chk_got(input string exp);
        chk("byte count", got.size(), exp.len());
        for (int i = 0; i < exp.len(); i++) chk("byte", {24'h0, got[i]}, {24'h0, exp[i]});
    endtask : chk_got

    task automatic cmd(input lpft_op_type op, input logic [3:0] num, input logic ser);
        int k;
        @(negedge i_clk);
        got.delete();
        over.delete();
        stamp.delete();
        {i_cmd_valid, i_cmd_num, i_cmd_serial} = {1'h1, num, ser};
        i_cmd_op = op;
        k = 0;
        do begin
            @(posedge i_clk);
            k++;
        end while (!o_cmd_ready && k < 500);
        @(negedge i_clk);
        i_cmd_valid = 1'h0;
    endtask : cmd

    task automatic settle();
        int k;
        k = 0;
        repeat (4) @(negedge i_clk);
        while (!(o_cmd_ready && !o_tx_valid) && k < 2000) begin
            @(negedge i_clk);
            k++;
        end
    endtask : settle

    // valid stays up between bytes; idle data lines show the inverse of the last byte
    task automatic push(input string s, input logic f);
        int k;
        for (int i = 0; i < s.len(); i++) begin
            @(negedge i_clk);
            {i_rx_valid, i_file_valid, i_file_last} = {!f, f, i == s.len() - 1};
            {i_rx_data, i_file_data} = {s[i], s[i]};
            k = 0;
            do begin
                @(posedge i_clk);
                k++;
            end while (!(f ? o_file_ready : o_rx_ready) && k < 500);
        end
        @(negedge i_clk);
        {i_rx_valid, i_file_valid} = 2'h0;
        {i_rx_data, i_file_data} = ~{i_rx_data, i_file_data};
    endtask : push

    task automatic learn(input logic [3:0] num, input logic ser);
        i_local_mode = ser;
        cmd(OP_LEARN, num, ser);
        push("B\nCD\nQ\n", 1'h0);
        repeat (3) @(negedge i_clk);
        chk("rx ready after quit line", o_rx_ready, 0);
        chk_got(ser ? "\021" : "");
    endtask : learn

    task automatic report_and_stop();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (40000) @(posedge i_clk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        {i_cmd_valid, i_cmd_serial, i_local_mode, i_halted, i_meas_busy, i_dump_format} = '0;
        {i_rx_valid, i_file_valid, i_file_last, i_limit_en, i_panel_exec, slow} = '0;
        {i_cmd_num, i_panel_num, i_rx_data, i_file_data, i_limit_hi} = '0;
        i_cmd_op = OP_NONE;
        i_term_char = 8'h2e;
        i_srst = 1'h1;
        repeat (3) @(negedge i_clk);
        i_srst = 1'h0;
        learn(4'h3, 1'h0);
        learn(4'h2, 1'h1);
        foreach (rows[r]) begin
            {i_local_mode, slow} = rows[r].fl[2:1];
            cmd(rows[r].op, rows[r].num, rows[r].fl[3]);
            settle();
            chk_got(rows[r].exp);
            chk("edit mode", o_edit_mode, rows[r].fl[0]);
            chk("tx port", o_tx_serial, rows[r].fl[3]);
            if (rows[r].op == OP_QUERY) chk("line count", o_count, rows[r].cnt);
            for (int i = 1; i < stamp.size() && rows[r].fl == 4'h0; i++) begin
                chk("bus pacing", stamp[i] - stamp[i - 1] >= 8, 1);
            end
        end
        i_meas_busy = 1'h1;
        cmd(OP_EXEC, 4'h3, 1'h1);
        repeat (8) @(negedge i_clk);
        chk("run while busy", nexec, 0);
        i_meas_busy = 1'h0;
        repeat (4) @(negedge i_clk);
        chk("run after busy", {nexec[3:0], last_num}, 8'h13);
        cmd(OP_EXEC, 4'h5, 1'h0);
        {i_panel_num, i_panel_exec} = {4'h2, 1'h1};
        @(negedge i_clk);
        i_panel_exec = 1'h0;
        repeat (4) @(negedge i_clk);
        chk("panel run", {nexec[3:0], last_num}, 8'h22);
        cmd(OP_CLEAR_FILE, 4'h1, 1'h0);
        repeat (3) @(negedge i_clk);
        chk("clear pulses", nclr, 1);
        cmd(OP_FILE_OUT, 4'h1, 1'h0);
        repeat (4) @(negedge i_clk);
        chk("file ready unhalted", o_file_ready, 0);
        {i_halted, i_local_mode, i_limit_en, i_limit_hi} = {3'h7, 8'h80};
        foreach (fexp[m]) begin
            i_dump_format = m == 1;
            cmd(OP_FILE_OUT, 4'h1, m == 0);
            push("A\n\220", 1'h1);
            settle();
            chk_got(fexp[m]);
            chk("file port", o_tx_serial, m == 0);
            chk("limit flags", {over[0], over[1], over[2]}, 3'h1);
        end
        cmd(OP_LIST, 4'h3, 1'h0);
        repeat (6) @(negedge i_clk);
        i_srst = 1'h1;
        repeat (3) @(negedge i_clk);
        chk("state in reset", {o_cmd_ready, o_tx_valid, o_edit_mode}, 3'h4);
        i_srst = 1'h0;
        cmd(OP_QUERY, 4'h3, 1'h0);
        settle();
        chk("count after reset", o_count, 0);
        report_and_stop();
    end
endmodule : learnt_program_file_transfer_tb
